// *** common/ccr_defines.svh ***
`ifndef CCR_DEFINES_SVH
`define CCR_DEFINES_SVH

// Register indices; the byte address is four times the index.
`define CCR_IDX_CMD 3'h0
`define CCR_IDX_DCR 3'h1
`define CCR_IDX_TCNT 3'h2
`define CCR_IDX_TMSK 3'h3
`define CCR_IDX_LAST 3'h3

// Command register values and masks.
`define CCR_CMD_HW_RST 16'h0094
`define CCR_CMD_SW_CLR 16'h0303
`define CCR_CMD_SW_SET 16'h0084
`define CCR_CMD_WMASK 16'h03BF

// Data configuration register layout.
`define CCR_DCR_HW_CLR 16'hA000
`define CCR_DCR_WMASK 16'hBCFF
`define CCR_DCR_BIT_EXBUS 15
`define CCR_DCR_BIT_LBR 13
`define CCR_DCR_USR_LSB 8

// Timer mask register field.
`define CCR_TMSK_BIT_DONE 0

`endif

// *** common/ccr_pkg.sv ***
package ccr_pkg;

   typedef struct packed {
      logic [5:0] zero_hi;
      logic load_filter_cmd;
      logic read_resource_cmd;
      logic soft_reset;
      logic zero6;
      logic timer_start_bit;
      logic timer_stop_bit;
      logic receive_enable_cmd;
      logic receive_disable_cmd;
      logic transmit_cmd;
      logic halt_transmit_cmd;
   } ccr_cmd_t;

   typedef struct packed {
      logic filter_done;
      logic resource_done;
      logic end_of_list_flag;
      logic tx_status_wr;
      logic excess_collision_flag;
      logic excess_deferral_flag;
      logic fifo_underrun_flag;
      logic byte_count_mismatch_flag;
      logic rx_busy;
   } ccr_eng_sts_t;

   typedef struct packed {
      logic soft_reset;
      logic crc_disable;
      logic tally_halt;
      logic rx_buffer_en;
   } ccr_ctl_t;

   typedef enum logic [1:0] {
      CCR_RX_OFF = 2'b01,
      CCR_RX_ON = 2'b10
   } ccr_rx_st_t;

endpackage : ccr_pkg

// *** design/ccr_timer.sv ***
`timescale 1ns/100ps
module ccr_timer #(
   parameter int unsigned WIDTH = 32
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Control
   input wire logic load,
   input wire logic [WIDTH-1:0] load_val,
   input wire logic run,
   // Status
   output logic [WIDTH-1:0] count,
   output logic expired
);

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   logic [WIDTH-1:0] count_q;
   logic expired_q;

   // The count parks at zero so a late start cannot wrap it round.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         count_q <= '0;
      end else if (load) begin
         count_q <= load_val;
      end else if (run && count_q != '0) begin
         count_q <= count_q - WIDTH'(1);
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         expired_q <= 1'b0;
      end else begin
         expired_q <= !load && run && count_q == WIDTH'(1);
      end
   end

   assign count = count_q;
   assign expired = expired_q;

   a_timer_decrement: assert property (run && !load && count_q != '0 |=> count_q == $past(count_q) - WIDTH'(1))
      else $error("timer did not decrement while running");
   a_timer_holds: assert property (!run && !load |=> $stable(count_q))
      else $error("timer moved while stopped");

endmodule : ccr_timer

// *** design/ccr_command_regs.sv ***
// Operation
// - Device clears every command bit except soft reset, timer start/stop and receive enable when its operation finishes.
// - Writing zero to a command bit other than soft reset changes nothing unless both receive bits are set.
// - Loaded 32-bit timer decrements only while the start bit is set.
// - Timer reaching zero raises the interrupt when its mask bit is enabled.
// - Hardware reset sets command bits 7, 4, 2 and clears all others.
// - Soft reset clears bits 9, 8, 1, 0, sets 7, 2, keeps others.
// - Soft reset holds state machines, disables CRC, halts tallies until cleared.
// - Load filter command loads filter memory from the filter descriptor pointer.
// - Read resource command fetches next receive resource descriptor.
// - Start bit starts timer and clears stop; stop halts and clears start.
// - Start and stop written together stop the timer.
// - Receive enable starts buffering, clears disable, waits for idle network.
// - Receive disable stops buffering after current packet, clears enable; tallies run.
// - With both receive bits set, writing zero to either clears it.
// - Transmit command loads transmit registers from descriptors and sends packets.
// - Transmit command clears on end of list, halt, or any abort.
// - Halt stops transmit after current packet and clears the transmit command.
// - Halt is sampled only after the packet status field is written.
// - Hardware reset clears configuration bits 15, 13; soft reset keeps all.
// - Configuration writes outside soft reset are ignored.
`timescale 1ns/100ps
`include "ccr_defines.svh"
module ccr_command_regs #(
   parameter int unsigned ADDR_W = 5,
   parameter int unsigned TIMER_W = 32
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Avalon-MM slave
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Engine status and straps
   input wire ccr_pkg::ccr_eng_sts_t eng_sts,
   input wire logic [1:0] usr_strap,
   // Engine control
   output ccr_pkg::ccr_cmd_t cmd,
   output ccr_pkg::ccr_ctl_t ctl,
   output logic [15:0] data_config,
   output logic timer_irq
);

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   ccr_pkg::ccr_cmd_t cmd_q;
   ccr_pkg::ccr_cmd_t cmd_d;
   ccr_pkg::ccr_cmd_t wcmd;
   ccr_pkg::ccr_rx_st_t rx_q;
   ccr_pkg::ccr_rx_st_t rx_d;
   logic last_en_q;
   logic last_en_d;
   logic acc_q;
   logic req;
   logic acc_wr;
   logic acc_rd;
   logic [2:0] idx;
   logic idx_ok;
   logic [31:0] lane_mask;
   logic [31:0] wdata;
   logic wr_cmd;
   logic wr_dcr;
   logic wr_tcnt;
   logic wr_tmsk;
   logic [31:0] readdata_q;
   logic [31:0] rd_mux;
   logic tx_abort;
   logic tx_end;
   logic halt_now;
   logic exbus_q;
   logic lbr_q;
   logic [15:0] dcr_rest_q;
   logic [1:0] usr_q;
   logic usr_taken_q;
   logic tmask_q;
   logic irq_q;
   logic [TIMER_W-1:0] tcount;
   logic texpired;
   logic boot_q;

   // Bus slave: one wait cycle, then the request is taken at the next edge.
   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & ~acc_q;
   assign acc_wr = avs_write & acc_q;
   assign acc_rd = avs_read & acc_q;
   assign idx = avs_address[4:2];
   assign idx_ok = avs_address[1:0] == 2'h0 && idx <= `CCR_IDX_LAST;
   assign lane_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                       {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   assign wdata = avs_writedata & lane_mask;
   assign wr_cmd = acc_wr && idx_ok && idx == `CCR_IDX_CMD;
   assign wr_dcr = acc_wr && idx_ok && idx == `CCR_IDX_DCR;
   assign wr_tcnt = acc_wr && idx_ok && idx == `CCR_IDX_TCNT;
   assign wr_tmsk = acc_wr && idx_ok && idx == `CCR_IDX_TMSK;
   assign wcmd = ccr_pkg::ccr_cmd_t'(wdata[15:0] & `CCR_CMD_WMASK);

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         acc_q <= 1'b0;
      end else begin
         acc_q <= req & ~acc_q;
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (idx_ok) begin
         case (idx)
            `CCR_IDX_CMD: rd_mux = {16'h0000, cmd_q};
            `CCR_IDX_DCR: rd_mux = {16'h0000, data_config};
            `CCR_IDX_TCNT: rd_mux = 32'(tcount);
            `CCR_IDX_TMSK: rd_mux = {31'h0000_0000, tmask_q};
            default: rd_mux = 32'h0000_0000;
         endcase
      end
   end

   // Read data is caught in the wait cycle and stands while waitrequest is low.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         readdata_q <= 32'h0000_0000;
      end else if (avs_read && !acc_q) begin
         readdata_q <= rd_mux;
      end
   end

   assign avs_readdata = readdata_q;

   // Transmit completion terms.
   assign tx_abort = eng_sts.excess_collision_flag | eng_sts.excess_deferral_flag |
                     eng_sts.fifo_underrun_flag | eng_sts.byte_count_mismatch_flag;
   assign tx_end = eng_sts.end_of_list_flag | tx_abort;
   assign halt_now = eng_sts.tx_status_wr && cmd_q.halt_transmit_cmd && cmd_q.transmit_cmd;

   // Completions are applied before host writes, so a set in the same cycle wins.
   always_comb begin
      cmd_d = cmd_q;
      last_en_d = last_en_q;
      rx_d = rx_q;
      if (eng_sts.filter_done) begin
         cmd_d.load_filter_cmd = 1'b0;
      end
      if (eng_sts.resource_done) begin
         cmd_d.read_resource_cmd = 1'b0;
      end
      if (tx_end || halt_now) begin
         cmd_d.transmit_cmd = 1'b0;
         cmd_d.halt_transmit_cmd = 1'b0;
      end
      if (cmd_q.halt_transmit_cmd && !cmd_q.transmit_cmd) begin
         cmd_d.halt_transmit_cmd = 1'b0;
      end
      if (wr_cmd) begin
         if (wcmd.soft_reset) begin
            cmd_d = ccr_pkg::ccr_cmd_t'((cmd_d & ~`CCR_CMD_SW_CLR) | `CCR_CMD_SW_SET);
            last_en_d = 1'b0;
         end else if (cmd_q.soft_reset) begin
            // Other bits of the write that leaves reset are dropped.
            cmd_d.soft_reset = 1'b0;
         end else begin
            if (cmd_q.receive_enable_cmd && cmd_q.receive_disable_cmd) begin
               cmd_d.receive_enable_cmd = wcmd.receive_enable_cmd;
               cmd_d.receive_disable_cmd = wcmd.receive_disable_cmd;
            end
            // Only ones take effect; zeros leave the bits alone.
            if (wcmd.load_filter_cmd) begin
               cmd_d.load_filter_cmd = 1'b1;
            end
            if (wcmd.read_resource_cmd) begin
               cmd_d.read_resource_cmd = 1'b1;
            end
            if (wcmd.transmit_cmd) begin
               cmd_d.transmit_cmd = 1'b1;
            end
            if (wcmd.halt_transmit_cmd) begin
               cmd_d.halt_transmit_cmd = 1'b1;
            end
            if (wcmd.timer_start_bit && wcmd.timer_stop_bit) begin
               cmd_d.timer_stop_bit = 1'b1;
               cmd_d.timer_start_bit = 1'b0;
            end else if (wcmd.timer_start_bit) begin
               cmd_d.timer_start_bit = 1'b1;
               cmd_d.timer_stop_bit = 1'b0;
            end else if (wcmd.timer_stop_bit) begin
               cmd_d.timer_stop_bit = 1'b1;
               cmd_d.timer_start_bit = 1'b0;
            end
            if (wcmd.receive_enable_cmd) begin
               cmd_d.receive_enable_cmd = 1'b1;
               last_en_d = 1'b1;
               cmd_d.receive_disable_cmd = cmd_d.receive_disable_cmd | (eng_sts.rx_busy && rx_q != ccr_pkg::CCR_RX_ON);
            end
            if (wcmd.receive_disable_cmd) begin
               cmd_d.receive_disable_cmd = 1'b1;
               last_en_d = 1'b0;
            end
         end
      end
      // The receive bits settle only while no packet is arriving.
      if (cmd_q.soft_reset || cmd_d.soft_reset) begin
         rx_d = ccr_pkg::CCR_RX_OFF;
      end else if (!eng_sts.rx_busy) begin
         if (cmd_d.receive_enable_cmd && (!cmd_d.receive_disable_cmd || last_en_d)) begin
            cmd_d.receive_disable_cmd = 1'b0;
            rx_d = ccr_pkg::CCR_RX_ON;
         end else if (cmd_d.receive_disable_cmd) begin
            cmd_d.receive_enable_cmd = 1'b0;
            cmd_d.receive_disable_cmd = 1'b0;
            rx_d = ccr_pkg::CCR_RX_OFF;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         cmd_q <= ccr_pkg::ccr_cmd_t'(`CCR_CMD_HW_RST);
      end else begin
         cmd_q <= cmd_d;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         last_en_q <= 1'b0;
      end else begin
         last_en_q <= last_en_d;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rx_q <= ccr_pkg::CCR_RX_OFF;
      end else begin
         case (rx_q)
            ccr_pkg::CCR_RX_OFF: rx_q <= rx_d;
            ccr_pkg::CCR_RX_ON: rx_q <= rx_d;
            default: rx_q <= ccr_pkg::CCR_RX_OFF;
         endcase
      end
   end

   // Configuration bits cleared by hardware reset.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         exbus_q <= 1'b0;
         lbr_q <= 1'b0;
      end else if (wr_dcr && cmd_q.soft_reset) begin
         if (lane_mask[`CCR_DCR_BIT_EXBUS]) begin
            exbus_q <= wdata[`CCR_DCR_BIT_EXBUS];
         end
         if (lane_mask[`CCR_DCR_BIT_LBR]) begin
            lbr_q <= wdata[`CCR_DCR_BIT_LBR];
         end
      end
   end

   // The remaining bits deliberately have no reset: a hardware reset keeps them.
   always_ff @(posedge clk_sys) begin
      if (wr_dcr && cmd_q.soft_reset) begin
         dcr_rest_q <= (dcr_rest_q & ~lane_mask[15:0]) | (wdata[15:0] & lane_mask[15:0]);
      end
   end

   // The user straps are caught at the first edge after reset is released.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         usr_taken_q <= 1'b0;
      end else begin
         usr_taken_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!usr_taken_q) begin
         usr_q <= usr_strap;
      end
   end

   assign data_config = {exbus_q, 1'b0, lbr_q, dcr_rest_q[12:10], usr_q, dcr_rest_q[7:0]};

   // Timer.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         tmask_q <= 1'b0;
      end else if (wr_tmsk && avs_byteenable[0]) begin
         tmask_q <= wdata[`CCR_TMSK_BIT_DONE];
      end
   end

   ccr_timer #(
      .WIDTH(TIMER_W)
   ) u_timer (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .load(wr_tcnt),
      .load_val(TIMER_W'((avs_writedata & lane_mask) | (32'(tcount) & ~lane_mask))),
      .run(cmd_q.timer_start_bit),
      .count(tcount),
      .expired(texpired)
   );

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= texpired && tmask_q;
      end
   end

   assign timer_irq = irq_q;
   assign cmd = cmd_q;
   // Tallies stop only in soft reset, never because the receiver is disabled.
   assign ctl.soft_reset = cmd_q.soft_reset;
   assign ctl.crc_disable = cmd_q.soft_reset;
   assign ctl.tally_halt = cmd_q.soft_reset;
   assign ctl.rx_buffer_en = rx_q == ccr_pkg::CCR_RX_ON;

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         boot_q <= 1'b1;
      end else begin
         boot_q <= 1'b0;
      end
   end

   a_hw_reset_cmd: assert property (boot_q |-> 16'(cmd_q) == `CCR_CMD_HW_RST)
      else $error("command register wrong after hardware reset");
   a_soft_reset_bits: assert property (wr_cmd && wcmd.soft_reset |=>
         (16'(cmd_q) & 16'h0387) == 16'h0084 && ((16'(cmd_q) ^ 16'($past(cmd_q))) & 16'h0030) == 16'h0000)
      else $error("soft reset set wrong command bits");
   a_filter_done_clr: assert property (eng_sts.filter_done && !wr_cmd |=> !cmd_q.load_filter_cmd)
      else $error("load filter bit not cleared on completion");
   a_zero_write_keeps: assert property (wr_cmd && !cmd_q.soft_reset && wdata[15:0] == 16'h0000 &&
         eng_sts == '0 && cmd_q.transmit_cmd && !cmd_q.halt_transmit_cmd |=> $stable(cmd_q))
      else $error("zero write changed the command register");
   a_both_stop: assert property (wr_cmd && !cmd_q.soft_reset && wcmd.timer_start_bit && wcmd.timer_stop_bit
         |=> cmd_q.timer_stop_bit && !cmd_q.timer_start_bit)
      else $error("start with stop did not stop the timer");
   a_rx_both_wait: assert property (eng_sts.rx_busy && !wr_cmd && cmd_q.receive_enable_cmd &&
         cmd_q.receive_disable_cmd && !cmd_q.soft_reset |=> cmd_q.receive_enable_cmd && cmd_q.receive_disable_cmd)
      else $error("receive bits resolved during a packet");
   a_tx_end_clear: assert property (tx_end && !(wr_cmd && wcmd.transmit_cmd) |=> !cmd_q.transmit_cmd)
      else $error("transmit command not cleared at end of transmit");
   a_halt_sampling: assert property (cmd_q.transmit_cmd && cmd_q.halt_transmit_cmd && !eng_sts.tx_status_wr &&
         !tx_end |=> cmd_q.transmit_cmd)
      else $error("halt taken before status write");
   a_dcr_locked: assert property (wr_dcr && !cmd_q.soft_reset |=> $stable(data_config))
      else $error("configuration changed outside soft reset");
   a_timer_irq: assert property (cmd_q.timer_start_bit && !wr_tcnt && tcount == TIMER_W'(1) && tmask_q
         |=> ##1 timer_irq)
      else $error("timer interrupt missing at zero");
   a_cmd_readback: assert property (acc_rd && idx == `CCR_IDX_CMD && avs_address[1:0] == 2'h0 |->
         avs_readdata[15:0] == 16'($past(cmd_q)))
      else $error("command readback does not match state");

   c_transmit_halt: cover property (cmd_q.transmit_cmd && cmd_q.halt_transmit_cmd ##[1:50] !cmd_q.transmit_cmd);
   c_rx_enable_wait: cover property (cmd_q.receive_enable_cmd && cmd_q.receive_disable_cmd ##[1:50] ctl.rx_buffer_en);
   c_timer_fires: cover property (timer_irq);

endmodule : ccr_command_regs

// *** testbench/ccr_tb.sv ***
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin mismatches++; \
   $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module testbench;
   logic clk_sys;
   logic sys_rst;
   logic [4:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   ccr_pkg::ccr_eng_sts_t eng_sts;
   logic [1:0] usr_strap;
   ccr_pkg::ccr_cmd_t cmd;
   ccr_pkg::ccr_ctl_t ctl;
   logic [15:0] data_config;
   logic timer_irq;
   int mismatches;
   int samples_checked;
   int seed;
   int irq_count;
   int k;
   int n;
   int n_tmr;
   logic [31:0] v;
   logic [31:0] rd;
   logic [15:0] dcr_exp;

   ccr_command_regs u_dut (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .avs_address(avs_address),
      .avs_read(avs_read),
      .avs_write(avs_write),
      .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .eng_sts(eng_sts),
      .usr_strap(usr_strap),
      .cmd(cmd),
      .ctl(ctl),
      .data_config(data_config),
      .timer_irq(timer_irq)
   );

   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      if (timer_irq === 1'b1) irq_count++;
   end

   // Straps appear in the read-only user bits; bit 14 always reads zero.
   function automatic logic [15:0] dcr_of(input logic [15:0] w);
      return (w & 16'hBCFF) | {6'h00, usr_strap, 8'h00};
   endfunction : dcr_of

   task automatic wrap_up;
      if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up

   // The request is held until waitrequest is seen low, never assuming a latency.
   task automatic bus(input logic is_wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
      int w;
      w = 0;
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= ~is_wr;
      avs_write <= is_wr;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0 && w < 50) begin
         @(posedge clk_sys);
         w++;
      end
      if (w >= 50) `CHK("bus handshake", 1'b0, avs_waitrequest)
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      bus(1'b1, a, d, rd);
   endtask : wr

   task automatic chk_cmd(input logic [15:0] e);
      bus(1'b0, 5'h00, 32'h0000_0000, rd);
      `CHK("cmd read", {16'h0000, e}, rd)
      `CHK("cmd port", e, cmd)
   endtask : chk_cmd

   task automatic chk_dcr;
      bus(1'b0, 5'h04, 32'h0000_0000, rd);
      `CHK("config read", {16'h0000, dcr_exp}, rd)
      `CHK("config port", dcr_exp, data_config)
   endtask : chk_dcr

   task automatic pulse(input int b);
      logic [8:0] p;
      p = 9'h000;
      p[b] = 1'b1;
      p[0] = eng_sts.rx_busy;
      @(posedge clk_sys);
      eng_sts <= ccr_pkg::ccr_eng_sts_t'(p);
      @(posedge clk_sys);
      eng_sts <= ccr_pkg::ccr_eng_sts_t'({8'h00, p[0]});
      @(negedge clk_sys);
   endtask : pulse

   task automatic set_rx(input logic b);
      @(posedge clk_sys);
      eng_sts.rx_busy <= b;
      repeat (3) @(negedge clk_sys);
   endtask : set_rx

   initial begin
      #(100 * 30000);
      mismatches++;
      wrap_up();
   end

   initial begin
      seed = 34;
      mismatches = 0;
      samples_checked = 0;
      irq_count = 0;
      sys_rst = 1'b1;
      avs_address = 5'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'hF;
      eng_sts = ccr_pkg::ccr_eng_sts_t'(9'h000);
      usr_strap = 2'($random(seed));
      repeat (10) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(negedge clk_sys);
      chk_cmd(16'h0094);
      `CHK("ctl in reset", 3'b111, {ctl.soft_reset, ctl.crc_disable, ctl.tally_halt})
      `CHK("config hw bits", 2'b00, {data_config[15], data_config[13]})
      v = $random(seed);
      wr(5'h04, v);
      dcr_exp = dcr_of(v[15:0]);
      chk_dcr();
      // The receiver is already off when reset is left, so its disable bit clears itself one cycle after soft reset drops.
      wr(5'h00, 32'h0000_0000);
      chk_cmd(16'h0010);
      `CHK("ctl running", 3'b000, {ctl.soft_reset, ctl.crc_disable, ctl.tally_halt})
      wr(5'h04, ~v);
      chk_dcr();
      wr(5'h00, 32'h0000_0000);
      chk_cmd(16'h0010);
      // Loaded count must sit still until the start bit arrives.
      n_tmr = 3 + int'($unsigned($random(seed)) % 20);
      wr(5'h0C, 32'h0000_0001);
      wr(5'h08, 32'(n_tmr));
      k = irq_count;
      repeat (3 * n_tmr) @(negedge clk_sys);
      `CHK("timer idle", k, irq_count)
      wr(5'h00, 32'h0000_0020);
      n = 0;
      while (irq_count == k && n < 200) begin
         @(negedge clk_sys);
         n++;
      end
      `CHK("timer span", 1'b1, (n >= n_tmr && n <= n_tmr + 4))
      chk_cmd(16'h0020);
      wr(5'h00, 32'h0000_0030);
      chk_cmd(16'h0010);
      wr(5'h0C, 32'h0000_0000);
      wr(5'h08, 32'h0000_0004);
      wr(5'h00, 32'h0000_0020);
      k = irq_count;
      repeat (20) @(negedge clk_sys);
      `CHK("masked irq", k, irq_count)
      wr(5'h00, 32'h0000_0010);
      chk_cmd(16'h0010);
      set_rx(1'b1);
      wr(5'h00, 32'h0000_0008);
      chk_cmd(16'h001C);
      `CHK("rx buffering", 1'b0, ctl.rx_buffer_en)
      set_rx(1'b0);
      chk_cmd(16'h0018);
      `CHK("rx buffering", 1'b1, ctl.rx_buffer_en)
      set_rx(1'b1);
      wr(5'h00, 32'h0000_0004);
      chk_cmd(16'h001C);
      `CHK("rx buffering", 1'b1, ctl.rx_buffer_en)
      wr(5'h00, 32'h0000_0004);
      chk_cmd(16'h0014);
      set_rx(1'b0);
      chk_cmd(16'h0010);
      `CHK("rx buffering", 1'b0, ctl.rx_buffer_en)
      // End of list and the four abort flags each end a transmission.
      for (int b = 1; b <= 6; b++) begin
         if (b != 5) begin
            wr(5'h00, 32'h0000_0002);
            chk_cmd(16'h0012);
            if (b == 1) begin
               wr(5'h00, 32'h0000_0000);
               chk_cmd(16'h0012);
            end
            pulse(b);
            chk_cmd(16'h0010);
         end
      end
      wr(5'h00, 32'h0000_0003);
      repeat (3) @(negedge clk_sys);
      chk_cmd(16'h0013);
      pulse(5);
      chk_cmd(16'h0010);
      wr(5'h00, 32'h0000_0001);
      chk_cmd(16'h0010);
      wr(5'h00, 32'h0000_0200);
      chk_cmd(16'h0210);
      pulse(8);
      chk_cmd(16'h0010);
      wr(5'h00, 32'h0000_0100);
      chk_cmd(16'h0110);
      pulse(7);
      chk_cmd(16'h0010);
      wr(5'h00, 32'h0000_0220);
      chk_cmd(16'h0220);
      wr(5'h00, 32'h0000_0080);
      chk_cmd(16'h00A4);
      `CHK("ctl soft reset", 3'b111, {ctl.soft_reset, ctl.crc_disable, ctl.tally_halt})
      chk_dcr();
      v = $random(seed);
      wr(5'h04, v);
      dcr_exp = dcr_of(v[15:0]);
      chk_dcr();
      // Only the low byte lane is written; the other lanes keep their bits.
      avs_byteenable <= 4'h1;
      wr(5'h04, ~v);
      avs_byteenable <= 4'hF;
      dcr_exp = dcr_of({dcr_exp[15:8], ~v[7:0]});
      chk_dcr();
      wr(5'h00, 32'h0000_0002);
      chk_cmd(16'h0020);
      bus(1'b0, 5'h14, 32'h0000_0000, rd);
      `CHK("unmapped read", 32'h0000_0000, rd)
      bus(1'b0, 5'h01, 32'h0000_0000, rd);
      `CHK("misaligned read", 32'h0000_0000, rd)
      wr(5'h14, 32'hFFFF_FFFF);
      chk_cmd(16'h0020);
      // A second hardware reset in mid-run keeps most configuration bits.
      @(posedge clk_sys);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      repeat (2) @(negedge clk_sys);
      dcr_exp = dcr_exp & 16'h5FFF;
      chk_cmd(16'h0094);
      `CHK("config after reset", dcr_exp, data_config)
      wrap_up();
   end
endmodule : testbench
